// ===== hdl/dpm_ck_gen.sv
// link clock divider with a fall strobe
`timescale 1ns/1ps
module dpm_ck_gen #(
  parameter int CK_DIV = 8
)(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  output logic ck_o,
  output logic fall_o
);
  localparam int CW = $clog2(CK_DIV);
  localparam logic [CW-1:0] LAST = CW'(CK_DIV - 1);
  localparam logic [CW-1:0] HALF_M1 = CW'(CK_DIV / 2 - 1);
  logic [CW-1:0] cnt_q;
  logic ck_q;
  if (CK_DIV < 2 || (CK_DIV % 2) != 0) begin : g_bad_div
    $error("dpm_ck_gen: CK_DIV must be even and at least 2");
  end
  // pins change together with the falling link edge, the far end samples on the rise
  assign fall_o = (cnt_q == HALF_M1);
  assign ck_o = ck_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
      ck_q <= 1'b1;
    end else begin
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
      ck_q <= (cnt_q == LAST) ? 1'b1 : (fall_o ? 1'b0 : ck_q);
    end
  end
endmodule

// ===== hdl/dpm_host.sv
// host that sequences power states and mode register writes of a ddr4 device
// Contract
// - every command is the cs/act/ras/cas/we/cke pattern sampled on a rising ck.
// - power-down entry and exit are sent with deselect only.
// - self-refresh exit carries deselect, or nop when gear-down is in use.
// - self-refresh entered only from idle, cke falling with a refresh.
// - a new cke level is held until one ck before tCKE.
// - deselect only during tXS after exit; odt waits for tXSDLL.
// - combinations outside the legal transitions are refused, never sent.
// - idle means cke high and all earlier timings satisfied.
// - all seven mode registers written before refresh or power states.
// - each mode write carries the full address field set.
// - mode writes only while idle with cke high.
// - mode writes spaced by at least tMRD.
// - mode writes changing pin behaviour wait for the update to finish.
// - only deselect until tMOD after a mode write; a further mode write is still sent once tMRD has passed.
// - listed special mode writes use the long wait instead of tMOD.
// - odt low for DODTLoff plus one ck before an rtt write, until tMOD.
// - rtt-affecting writes are flagged by software per command.
// - odt may rise again once tMOD has expired.
`timescale 1ns/1ps
module dpm_host #(
  parameter int CK_DIV = dpm_pkg::CK_DIV_DEF,
  parameter int T_XSDLL = dpm_pkg::T_XSDLL_NCK_DEF
)(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic ddr_ck_o,
  output logic ddr_cke_o,
  output logic ddr_cs_n_o,
  output logic ddr_act_n_o,
  output logic ddr_ras_n_o,
  output logic ddr_cas_n_o,
  output logic ddr_we_n_o,
  output logic [1:0] ddr_ba_o,
  output logic ddr_bg_o,
  output logic [13:0] ddr_addr_o,
  output logic ddr_odt_o
);
  localparam int TW = dpm_pkg::TW;
  localparam logic [TW-1:0] T_XSDLL_V = TW'(T_XSDLL);
  localparam int MRD_CLK = int'(dpm_pkg::T_MRD_NCK) * CK_DIV;
  localparam int CKE_CLK = (int'(dpm_pkg::T_CKE_NCK) - 1) * CK_DIV;
  if (T_XSDLL < int'(dpm_pkg::T_XS_NCK) || T_XSDLL >= (1 << TW)) begin : g_bad_xsdll
    $error("dpm_host: T_XSDLL must cover tXS and fit the timer");
  end

  function automatic logic [TW-1:0] dec(input logic [TW-1:0] t);
    return (t == '0) ? '0 : t - 1'b1;
  endfunction
  // legality by current state and init status; timing holds the command back, not refuses it
  function automatic logic op_legal(input dpm_pkg::dpm_state_t st, input logic [2:0] op,
                                    input logic init);
    logic ok;
    ok = 1'b0;
    unique case (op)
      dpm_pkg::OP_MRS: ok = (st == dpm_pkg::HS_IDLE);
      dpm_pkg::OP_REF, dpm_pkg::OP_SRE, dpm_pkg::OP_PDE: ok = (st == dpm_pkg::HS_IDLE) && init;
      dpm_pkg::OP_SRX: ok = (st == dpm_pkg::HS_SR);
      dpm_pkg::OP_PDX: ok = (st == dpm_pkg::HS_PD);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  logic fall;
  logic cmd_we;
  logic [dpm_pkg::CMD_W-1:0] cmd_dat;
  logic [dpm_pkg::MRS_W-1:0] mrs_word;
  logic odt_en;
  logic stat_clr;
  logic [31:0] stat;
  dpm_pkg::dpm_state_t st_q, st_d;
  logic pend_q, rtt_q, long_q, gear_q, refused_q;
  logic [2:0] op_q;
  logic [dpm_pkg::MRS_W-1:0] pmrs_q;
  logic [6:0] mr_done_q;
  logic [TW-1:0] mrd_q, mod_q, ckeh_q, xs_q, xsdll_q, odth_q, lowck_q;
  logic cke_q, cs_n_q, ras_n_q, cas_n_q, we_n_q, odt_q, bg_q;
  logic [1:0] ba_q;
  logic [13:0] addr_q;
  logic iss_mrs_q, iss_rtt_q, iss_pwr_q;

  dpm_ck_gen #(.CK_DIV(CK_DIV)) u_ck (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .ck_o(ddr_ck_o),
    .fall_o(fall)
  );
  dpm_wb_regs u_regs (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .cmd_we_o(cmd_we),
    .cmd_dat_o(cmd_dat),
    .mrs_word_o(mrs_word),
    .odt_en_o(odt_en),
    .stat_clr_o(stat_clr),
    .stat_i(stat)
  );

  wire logic init_done = (mr_done_q == dpm_pkg::MR_ALL);
  wire logic [2:0] new_op = cmd_dat[dpm_pkg::CMD_OP_LSB +: 3];
  wire logic [2:0] new_mr = mrs_word[dpm_pkg::MRS_SEL_LSB +: 3];
  wire logic [2:0] cur_mr = pmrs_q[dpm_pkg::MRS_SEL_LSB +: 3];
  // a mode write is bound to the register word present when the command is taken
  wire logic accept = cmd_we && !pend_q && op_legal(st_q, new_op, init_done) &&
                      !(new_op == dpm_pkg::OP_MRS && new_mr == dpm_pkg::MR_RESERVED);
  wire logic refuse = cmd_we && !accept;
  wire logic odt_ready = !rtt_q || (lowck_q > dpm_pkg::DODTLOFF_NCK);
  wire logic idle_ok = (st_q == dpm_pkg::HS_IDLE) && cke_q && (mod_q == '0);
  wire logic run = fall && pend_q;
  wire logic go_mrs = run && op_q == dpm_pkg::OP_MRS && st_q == dpm_pkg::HS_IDLE && cke_q &&
                      mrd_q == '0 && odt_ready;
  wire logic go_ref = run && op_q == dpm_pkg::OP_REF && idle_ok && mrd_q == '0;
  wire logic go_sre = run && op_q == dpm_pkg::OP_SRE && idle_ok && ckeh_q == '0;
  wire logic go_pde = run && op_q == dpm_pkg::OP_PDE && idle_ok && ckeh_q == '0;
  wire logic go_srx = run && op_q == dpm_pkg::OP_SRX && ckeh_q == '0;
  wire logic go_pdx = run && op_q == dpm_pkg::OP_PDX && ckeh_q == '0;
  wire logic go_any = go_mrs || go_ref || go_sre || go_pde || go_srx || go_pdx;
  wire logic cke_drop = go_sre || go_pde;
  wire logic cke_rise = go_srx || go_pdx;
  // power-down edges carry deselect; self-refresh exit may carry nop in gear-down
  wire logic nx_cs_n = !(go_mrs || go_ref || go_sre || (go_srx && gear_q));
  wire logic nx_rc_n = !(go_mrs || go_ref || go_sre);
  wire logic nx_we_n = !go_mrs;
  wire logic [TW-1:0] mod_len = long_q ? dpm_pkg::T_LONG_NCK : dpm_pkg::T_MOD_NCK;
  wire logic [TW-1:0] mrd_len = long_q ? dpm_pkg::T_LONG_NCK : dpm_pkg::T_MRD_NCK;
  wire logic [TW-1:0] gap_ld = go_mrs ? mrd_len : go_ref ? dpm_pkg::T_RFC_NCK :
                               go_srx ? dpm_pkg::T_XS_NCK : dpm_pkg::T_XP_NCK;
  wire logic [TW-1:0] mod_ld = go_mrs ? mod_len : gap_ld;
  wire logic gap_hit = go_mrs || go_ref || go_srx || go_pdx;
  wire logic odt_d = odt_en && st_q != dpm_pkg::HS_SR && !go_sre && xsdll_q == '0 &&
                     odth_q == '0 && !(pend_q && rtt_q);

  always_comb begin
    st_d = st_q;
    if (go_sre) begin
      st_d = dpm_pkg::HS_SR;
    end else if (go_pde) begin
      st_d = dpm_pkg::HS_PD;
    end else if (cke_rise) begin
      st_d = dpm_pkg::HS_IDLE;
    end
  end

  // request holding: one operation at a time, taken from the register port
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_q <= 1'b0;
      op_q <= dpm_pkg::OP_NONE;
      rtt_q <= 1'b0;
      long_q <= 1'b0;
      gear_q <= 1'b0;
      pmrs_q <= '0;
      refused_q <= 1'b0;
    end else begin
      refused_q <= refuse | (refused_q & ~stat_clr);
      if (accept) begin
        pend_q <= 1'b1;
        op_q <= new_op;
        rtt_q <= cmd_dat[dpm_pkg::CMD_RTT_BIT] && new_op == dpm_pkg::OP_MRS;
        long_q <= cmd_dat[dpm_pkg::CMD_LONG_BIT];
        gear_q <= cmd_dat[dpm_pkg::CMD_GEAR_BIT];
        pmrs_q <= mrs_word;
      end else if (go_any) begin
        pend_q <= 1'b0;
      end
    end
  end

  // link timers, all counted in link clock cycles
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mrd_q <= '0;
      mod_q <= '0;
      ckeh_q <= '0;
      xs_q <= '0;
      xsdll_q <= '0;
      odth_q <= '0;
      lowck_q <= '0;
    end else if (fall) begin
      mrd_q <= gap_hit ? gap_ld : dec(mrd_q);
      mod_q <= gap_hit ? mod_ld : dec(mod_q);
      ckeh_q <= (cke_drop || cke_rise) ? dpm_pkg::T_CKE_NCK - 1'b1 : dec(ckeh_q);
      xs_q <= go_srx ? dpm_pkg::T_XS_NCK : dec(xs_q);
      xsdll_q <= go_srx ? T_XSDLL_V : dec(xsdll_q);
      odth_q <= (go_mrs && rtt_q) ? mod_len : dec(odth_q);
      lowck_q <= odt_q ? '0 : ((&lowck_q) ? lowck_q : lowck_q + 1'b1);
    end
  end

  // pins update on the falling link edge so they are settled at the rise
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= dpm_pkg::HS_IDLE;
      cke_q <= 1'b1;
      cs_n_q <= 1'b1;
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      we_n_q <= 1'b1;
      odt_q <= 1'b0;
      bg_q <= 1'b0;
      ba_q <= 2'h0;
      addr_q <= 14'h0000;
    end else if (fall) begin
      st_q <= st_d;
      cke_q <= cke_drop ? 1'b0 : (cke_rise ? 1'b1 : cke_q);
      cs_n_q <= nx_cs_n;
      ras_n_q <= nx_rc_n;
      cas_n_q <= nx_rc_n;
      we_n_q <= nx_we_n;
      odt_q <= odt_d;
      if (go_mrs) begin
        {bg_q, ba_q} <= cur_mr;
        addr_q <= pmrs_q[dpm_pkg::MRS_ADDR_W-1:0];
      end
    end
  end

  // mode-register coverage and one-cycle issue markers used for checking
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mr_done_q <= 7'h00;
      iss_mrs_q <= 1'b0;
      iss_rtt_q <= 1'b0;
      iss_pwr_q <= 1'b0;
    end else begin
      if (go_mrs) begin
        mr_done_q[cur_mr] <= 1'b1;
      end
      iss_mrs_q <= go_mrs;
      iss_rtt_q <= go_mrs && rtt_q;
      iss_pwr_q <= go_ref || go_sre || go_pde;
    end
  end

  assign ddr_cke_o = cke_q;
  assign ddr_cs_n_o = cs_n_q;
  assign ddr_act_n_o = 1'b1;
  assign ddr_ras_n_o = ras_n_q;
  assign ddr_cas_n_o = cas_n_q;
  assign ddr_we_n_o = we_n_q;
  assign ddr_bg_o = bg_q;
  assign ddr_ba_o = ba_q;
  assign ddr_addr_o = addr_q;
  assign ddr_odt_o = odt_q;
  assign stat = {18'h0_0000, cke_q, odt_q, init_done, mr_done_q, refused_q, pend_q, st_q};

  // helper counters, core cycles since the last cke change and last mode write
  logic [15:0] cke_age_q, since_mrs_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cke_age_q <= 16'hFFFF;
      since_mrs_q <= 16'hFFFF;
    end else begin
      cke_age_q <= (cke_q != (cke_drop ? 1'b0 : cke_rise ? 1'b1 : cke_q)) ? 16'h0000 :
                   ((&cke_age_q) ? cke_age_q : cke_age_q + 1'b1);
      since_mrs_q <= go_mrs ? 16'h0000 : ((&since_mrs_q) ? since_mrs_q : since_mrs_q + 1'b1);
    end
  end
  wire logic mrs_pins = !cs_n_q && !ras_n_q && !cas_n_q && !we_n_q;
  wire logic nop_pins = !cs_n_q && ras_n_q && cas_n_q && we_n_q;

  property p_cke_des;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $changed(cke_q) && st_q != dpm_pkg::HS_SR |->
        cs_n_q || ($past(st_q) == dpm_pkg::HS_SR && nop_pins);
  endproperty
  a_cke_des: assert property (p_cke_des) else $error("cke edge without deselect");
  property p_sre_idle;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $fell(cke_q) && !cs_n_q |-> $past(st_q) == dpm_pkg::HS_IDLE && !ras_n_q && we_n_q;
  endproperty
  a_sre_idle: assert property (p_sre_idle) else $error("self-refresh not from idle");
  property p_cke_hold;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $changed(cke_q) |-> $past(cke_age_q) >= 16'(CKE_CLK);
  endproperty
  a_cke_hold: assert property (p_cke_hold) else $error("cke toggled too early");
  property p_xs_des;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      xs_q != '0 && xs_q != dpm_pkg::T_XS_NCK |-> cs_n_q && !odt_q;
  endproperty
  a_xs_des: assert property (p_xs_des) else $error("command inside tXS");
  property p_sr_odt;
    @(posedge core_clk_i) disable iff (!reset_n_i) st_q == dpm_pkg::HS_SR |-> !odt_q;
  endproperty
  a_sr_odt: assert property (p_sr_odt) else $error("odt high in self-refresh");
  property p_odt_xsdll;
    @(posedge core_clk_i) disable iff (!reset_n_i) xsdll_q != '0 |-> !odt_q;
  endproperty
  a_odt_xsdll: assert property (p_odt_xsdll) else $error("odt high before tXSDLL");
  property p_mrs_idle;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      iss_mrs_q |-> mrs_pins && cke_q && $past(st_q) == dpm_pkg::HS_IDLE;
  endproperty
  a_mrs_idle: assert property (p_mrs_idle) else $error("mode write while not idle");
  property p_mrd;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      iss_mrs_q |-> $past(since_mrs_q) >= 16'(MRD_CLK);
  endproperty
  a_mrd: assert property (p_mrd) else $error("mode writes closer than tMRD");
  property p_mod_des;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $past(mod_q) != '0 && !iss_mrs_q && $past(fall) |-> cs_n_q || mrs_pins;
  endproperty
  a_mod_des: assert property (p_mod_des) else $error("non-deselect inside tMOD");
  sequence s_odt_low_before;
    !odt_q && $past(lowck_q) > dpm_pkg::DODTLOFF_NCK;
  endsequence
  property p_odt_rtt;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      iss_rtt_q |-> s_odt_low_before ##1 (!odt_q)[*8];
  endproperty
  a_odt_rtt: assert property (p_odt_rtt) else $error("odt not low around rtt write");
  property p_init;
    @(posedge core_clk_i) disable iff (!reset_n_i) iss_pwr_q |-> init_done;
  endproperty
  a_init: assert property (p_init) else $error("power command before init");
endmodule

// ===== hdl/dpm_wb_regs.sv
// classic wishbone slave holding the host's own control registers
`timescale 1ns/1ps
module dpm_wb_regs (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic cmd_we_o,
  output logic [dpm_pkg::CMD_W-1:0] cmd_dat_o,
  output logic [dpm_pkg::MRS_W-1:0] mrs_word_o,
  output logic odt_en_o,
  output logic stat_clr_o,
  input wire logic [31:0] stat_i
);
  logic ack_q;
  logic [31:0] dat_q;
  logic [dpm_pkg::MRS_W-1:0] mrs_q;
  logic odt_q;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
  // the request acts in its first cycle; ack follows on the next edge
  wire logic go = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic wr = go && wb_we_i;
  wire logic hit_cmd = (wb_adr_i == dpm_pkg::REG_CMD);
  wire logic hit_mrs = (wb_adr_i == dpm_pkg::REG_MRS);
  wire logic hit_odt = (wb_adr_i == dpm_pkg::REG_ODT);
  wire logic hit_stat = (wb_adr_i == dpm_pkg::REG_STAT);
  wire logic [31:0] mrs_m = merge({15'h0000, mrs_q}, wb_dat_i, wb_sel_i);
  wire logic [31:0] rd_mux = hit_mrs ? {15'h0000, mrs_q} :
                             hit_odt ? {31'h0000_0000, odt_q} :
                             hit_stat ? stat_i : 32'h0000_0000;
  assign cmd_we_o = wr && hit_cmd && wb_sel_i[0];
  assign cmd_dat_o = wb_dat_i[dpm_pkg::CMD_W-1:0];
  assign stat_clr_o = wr && hit_stat && wb_sel_i[0] && wb_dat_i[dpm_pkg::ST_REFUSED_BIT];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign mrs_word_o = mrs_q;
  assign odt_en_o = odt_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      mrs_q <= '0;
      odt_q <= 1'b0;
    end else begin
      ack_q <= go;
      dat_q <= go ? rd_mux : 32'h0000_0000;
      if (wr && hit_mrs) begin
        mrs_q <= mrs_m[dpm_pkg::MRS_W-1:0];
      end
      if (wr && hit_odt && wb_sel_i[0]) begin
        odt_q <= wb_dat_i[0];
      end
    end
  end
endmodule

// ===== pkg/dpm_pkg.sv
// shared constants and types for the dram power-state and mode-program host
package dpm_pkg;
  // link clock divider: ck period is CK_DIV core cycles
  localparam int CK_DIV_DEF = 8;
  localparam int TW = 10;
  // link timings in link clock cycles (nCK)
  localparam logic [9:0] T_MRD_NCK = 10'h008;
  localparam logic [9:0] T_MOD_NCK = 10'h018;
  localparam logic [9:0] T_CKE_NCK = 10'h003;
  localparam logic [9:0] T_XS_NCK = 10'h028;
  localparam logic [9:0] T_XP_NCK = 10'h008;
  localparam logic [9:0] T_RFC_NCK = 10'h020;
  localparam logic [9:0] T_LONG_NCK = 10'h040;
  localparam logic [9:0] DODTLOFF_NCK = 10'h00A;
  localparam int T_XSDLL_NCK_DEF = 64;
  // register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_MRS = 8'h04;
  localparam logic [7:0] REG_ODT = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_RTT_BIT = 3;
  localparam int CMD_LONG_BIT = 4;
  localparam int CMD_GEAR_BIT = 5;
  localparam int CMD_W = 6;
  // mode register word: address bits, then mode register number
  localparam int MRS_ADDR_W = 14;
  localparam int MRS_SEL_LSB = 14;
  localparam int MRS_W = 17;
  localparam logic [2:0] MR_RESERVED = 3'h7;
  localparam logic [6:0] MR_ALL = 7'h7F;
  // status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_PEND_BIT = 2;
  localparam int ST_REFUSED_BIT = 3;
  localparam int ST_MASK_LSB = 4;
  localparam int ST_INIT_BIT = 11;
  localparam int ST_ODT_BIT = 12;
  localparam int ST_CKE_BIT = 13;
  // operations
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_MRS = 3'h1;
  localparam logic [2:0] OP_REF = 3'h2;
  localparam logic [2:0] OP_SRE = 3'h3;
  localparam logic [2:0] OP_SRX = 3'h4;
  localparam logic [2:0] OP_PDE = 3'h5;
  localparam logic [2:0] OP_PDX = 3'h6;
  typedef enum logic [1:0] {HS_IDLE, HS_PD, HS_SR} dpm_state_t;
endpackage

// ===== verif/dpm_dev_model.sv
// behavioural ddr4 device that decodes commands and counts protocol breaches
`timescale 1ns/1ps
module dpm_dev_model #(
  parameter int T_XSDLL = 64
)(
  input wire logic ck_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic act_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] mr_i,
  input wire logic [13:0] addr_i,
  input wire logic odt_i,
  output logic [1:0] state_o,
  output int err_o,
  output logic [16:0] mr_o,
  output int odt_low_o
);
  localparam int MRD = int'(dpm_pkg::T_MRD_NCK);
  localparam int MOD = int'(dpm_pkg::T_MOD_NCK);
  localparam int XS = int'(dpm_pkg::T_XS_NCK);
  localparam int CKE = int'(dpm_pkg::T_CKE_NCK);
  int nck = 0;
  int t_mrs = -999;
  int t_cke = -999;
  int t_srx = -999;
  int low_n = 0;
  logic cke_q = 1'b1;
  logic odt_q = 1'b0;
  wire des_w = cs_n_i;
  wire cmd_w = !cs_n_i && act_n_i && !ras_n_i && !cas_n_i;
  wire mrs_w = cmd_w && !we_n_i;
  wire ref_w = cmd_w && we_n_i;
  wire nop_w = !cs_n_i && act_n_i && ras_n_i && cas_n_i && we_n_i;
  initial begin
    state_o = 2'h0;
    err_o = 0;
    mr_o = 17'h0_0000;
    odt_low_o = 0;
  end
  // everything is judged at the rising ck edge, as the device registers it
  always @(posedge ck_i) begin
    nck++;
    if (cke_i !== cke_q && !$isunknown(cke_i)) begin
      if (nck - t_cke < CKE - 1) err_o++;
      t_cke = nck;
      if (!cke_i && ref_w) begin
        if (state_o != 2'h0 || nck - t_mrs < MOD) err_o++;
        state_o = 2'h2;
      end else if (!des_w && !(nop_w && state_o == 2'h2)) begin
        err_o++;
      end else begin
        if (state_o == 2'h2) t_srx = nck;
        state_o = cke_i ? 2'h0 : 2'h1; // no bank is ever open, so precharge power-down
      end
    end else if (cke_i && !des_w) begin // pins are ignored while cke is low
      if (nck - t_srx < XS) err_o++;
      if (mrs_w) begin
        if (nck - t_mrs < MRD) err_o++;
        t_mrs = nck;
        mr_o = {mr_i, addr_i};
        odt_low_o = low_n;
      end else if (nck - t_mrs < MOD) err_o++;
    end
    if (odt_i && (state_o == 2'h2 || nck - t_srx < T_XSDLL)) err_o++;
    if (odt_i && !odt_q && nck - t_mrs < MOD) err_o++;
    low_n = odt_i ? 0 : low_n + 1;
    cke_q = cke_i;
    odt_q = odt_i;
  end
endmodule

// ===== verif/dpm_host_tb_top.sv
// self-checking bench for the power-state and mode-write host
`timescale 1ns/1ps
module dpm_host_tb_top;
  localparam int CKD = 8;
  localparam int TXSDLL = 64;
  logic clk;
  logic rst_n;
  logic cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, wd;
  wire [31:0] dat_o;
  wire ack, ck, cke, cs_n, act_n, ras_n, cas_n, we_n, bg, odt;
  wire [1:0] ba;
  wire [13:0] addr;
  wire [1:0] m_state;
  wire [16:0] m_mr;
  int m_err, m_odt_low;
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 32'habdb;

  dpm_host #(.CK_DIV(CKD), .T_XSDLL(TXSDLL)) u_dpm_host (.core_clk_i(clk), .reset_n_i(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .ddr_ck_o(ck), .ddr_cke_o(cke),
    .ddr_cs_n_o(cs_n), .ddr_act_n_o(act_n), .ddr_ras_n_o(ras_n), .ddr_cas_n_o(cas_n),
    .ddr_we_n_o(we_n), .ddr_ba_o(ba), .ddr_bg_o(bg), .ddr_addr_o(addr), .ddr_odt_o(odt));

  dpm_dev_model #(.T_XSDLL(TXSDLL)) u_dpm_dev_model (.ck_i(ck), .cke_i(cke), .cs_n_i(cs_n),
    .act_n_i(act_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .mr_i({bg, ba}),
    .addr_i(addr), .odt_i(odt), .state_o(m_state), .err_o(m_err), .mr_o(m_mr),
    .odt_low_o(m_odt_low));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one classic cycle; ack is read at the edge, before that edge's updates land
  function automatic logic [31:0] mr_word(input logic [2:0] mr, input logic [13:0] a);
    return {15'h0, mr, a};
  endfunction

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    chk("ack released", 32'h0000_0000, {31'h0, ack});
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // issue a command and wait until the host has launched it on the link
  task automatic op(input logic [5:0] c);
    wb(1'b1, dpm_pkg::REG_CMD, {26'h0, c});
    do begin
      wb(1'b0, dpm_pkg::REG_STAT, 32'h0000_0000);
    end while (rdat[dpm_pkg::ST_PEND_BIT] !== 1'b0);
    repeat (2 * CKD) @(posedge clk);
  endtask

  task automatic st(input logic [1:0] e);
    wb(1'b0, dpm_pkg::REG_STAT, 32'h0000_0000);
    chk("host state", {30'h0, e}, {30'h0, rdat[1:0]});
    chk("device state", {30'h0, e}, {30'h0, m_state});
  endtask

  task automatic rf(input logic e);
    wb(1'b0, dpm_pkg::REG_STAT, 32'h0000_0000);
    chk("refused flag", {31'h0, e}, {31'h0, rdat[dpm_pkg::ST_REFUSED_BIT]});
    if (rdat[dpm_pkg::ST_REFUSED_BIT]) wb(1'b1, dpm_pkg::REG_STAT, 32'h0000_0008);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // the whole run is some 2200 core cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_sim();
  end

  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    chk("cke cs odt", 32'h0000_0006, {29'h0, cke, cs_n, odt});
    st(2'h0);
    chk("status after reset", 32'h0000_2000, rdat & 32'h0000_3fff);
    op({3'b000, dpm_pkg::OP_REF});
    rf(1'b1);
    wb(1'b1, dpm_pkg::REG_MRS, {15'h0, dpm_pkg::MR_RESERVED, 14'h0});
    op({3'b000, dpm_pkg::OP_MRS});
    rf(1'b1);
    // back-to-back writes of every mode register, the last with the long wait
    for (int i = 0; i < 7; i++) begin
      wd = mr_word(i[2:0], 14'($random(seed)));
      wb(1'b1, dpm_pkg::REG_MRS, wd);
      op({1'b0, i == 6, 1'b0, dpm_pkg::OP_MRS});
      chk("mode word", wd, {15'h0, m_mr});
    end
    rf(1'b0);
    chk("written mask", 32'h0000_00ff, {24'h0, rdat[11:4]});
    op({3'b000, dpm_pkg::OP_PDE});
    st(2'h1);
    op({3'b000, dpm_pkg::OP_REF});
    rf(1'b1);
    op({3'b000, dpm_pkg::OP_MRS});
    rf(1'b1);
    op({3'b000, dpm_pkg::OP_PDX});
    st(2'h0);
    op({3'b000, dpm_pkg::OP_SRE});
    st(2'h2);
    wb(1'b1, dpm_pkg::REG_ODT, 32'h0000_0001);
    op({3'b000, dpm_pkg::OP_PDE});
    rf(1'b1);
    chk("odt in self-refresh", 32'h0000_0000, {31'h0, odt});
    op({3'b100, dpm_pkg::OP_SRX});
    st(2'h0);
    repeat ((TXSDLL + 4) * CKD) @(posedge clk);
    chk("odt after exit", 32'h0000_0001, {31'h0, odt});
    wd = mr_word(3'h1, 14'($random(seed)));
    wb(1'b1, dpm_pkg::REG_MRS, wd);
    op({3'b001, dpm_pkg::OP_MRS});
    chk("odt low run", 32'h0000_0001, {31'h0, m_odt_low > int'(dpm_pkg::DODTLOFF_NCK)});
    chk("odt held low", 32'h0000_0000, {31'h0, odt});
    repeat ((int'(dpm_pkg::T_MOD_NCK) + 4) * CKD) @(posedge clk);
    chk("odt back high", 32'h0000_0001, {31'h0, odt});
    wb(1'b0, 8'h40, 32'hffff_ffff);
    chk("unmapped read", 32'h0000_0000, rdat);
    chk("device breaches", 32'h0000_0000, m_err);
    end_sim();
  end
endmodule
